// ===== logic/cfgl_loader.sv
// Function
// - pad driven after a clean load when enable bit set, else tri-state
// - three-bit drive code decodes to pad current
// - right extension from upper nibble of 268
// - left extension from lower nibble of 268
// - down extension from low bits of 269
// - checksum is low byte of preceding sum
`timescale 1ns/1ps
module cfgl_loader (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // serial memory pins, open drain
    input  wire logic       ee_sda_in,
    output logic            ee_sda_out,
    output logic            ee_sda_oe_n,
    output logic            ee_scl_out,
    output logic            ee_scl_oe_n,
    // pad sources from the timing logic
    input  wire logic       de_src,
    input  wire logic       line_sync_src,
    input  wire logic       frame_sync_src,
    input  wire logic       panel_clock_src,
    // panel pads
    output logic            display_enable_out,
    output logic            display_enable_oe_n,
    output logic [3:0]      display_enable_drive_ma,
    output logic            line_sync_out,
    output logic            line_sync_oe_n,
    output logic [3:0]      line_sync_drive_ma,
    output logic            frame_sync_out,
    output logic            frame_sync_oe_n,
    output logic [3:0]      frame_sync_drive_ma,
    output logic            panel_clock_out,
    output logic            panel_clock_oe_n,
    output logic [3:0]      panel_clock_drive_ma,
    // loaded settings and status
    output logic [3:0]      ext_right,
    output logic [3:0]      ext_left,
    output logic [1:0]      ext_down,
    output logic            load_done,
    output logic            checksum_error,
    output logic            eeprom_nack_error
);

    typedef enum logic [2:0] {
        S_START1, S_DEVW, S_ADDR, S_START2, S_DEVR, S_READ, S_STOP, S_DONE
    } cfgl_state_e;

    cfgl_state_e         state_q;
    logic                wait_q;
    logic [10:0]         addr_q;
    logic [7:0]          sum_q;
    logic [7:0]          sync_enable_pad_ctrl_q;
    logic [7:0]          frame_clock_pad_ctrl_q;
    logic [7:0]          horizontal_extension_q;
    logic [1:0]          vertical_extension_q;
    logic [7:0]          table_checksum_q;
    logic                cfg_ok;
    logic                sda_s1_q;
    logic                sda_s2_q;
    logic                sda_s3_q;
    logic                sda_v_q;
    logic                cmd_valid;
    cfgl_pkg::cfgl_cmd_e cmd;
    logic [7:0]          wdata;
    logic                send_ack;
    logic                byte_done;
    logic [7:0]          rdata;
    logic                ack_seen;
    logic [7:0]          dev_word;

    // open drain: the pin only ever pulls low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ee_sda_out <= 1'b0;
            ee_scl_out <= 1'b0;
        end else begin
            ee_sda_out <= 1'b0;
            ee_scl_out <= 1'b0;
        end
    end

    // three-stage input sync; accept a level once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
            sda_v_q  <= 1'b1;
        end else begin
            sda_s1_q <= ee_sda_in;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
            if (sda_s2_q == sda_s3_q) begin
                sda_v_q <= sda_s3_q;
            end
        end
    end

    // random read to the part start, then one sequential read to the end
    assign dev_word = {cfgl_pkg::EE_DEV_HI, cfgl_pkg::PART_START[10:8], 1'b0};

    always_comb begin
        cmd_valid = !wait_q && (state_q != S_DONE);
        cmd       = cfgl_pkg::CFGL_CMD_WRITE;
        wdata     = 8'h00;
        send_ack  = (addr_q != cfgl_pkg::OFS_CSUM);
        case (state_q)
            S_START1: cmd = cfgl_pkg::CFGL_CMD_START;
            S_START2: cmd = cfgl_pkg::CFGL_CMD_START;
            S_DEVW:   wdata = dev_word;
            S_ADDR:   wdata = cfgl_pkg::PART_START[7:0];
            S_DEVR:   wdata = dev_word | 8'h01;
            S_READ:   cmd = cfgl_pkg::CFGL_CMD_READ;
            S_STOP:   cmd = cfgl_pkg::CFGL_CMD_STOP;
            default:  cmd = cfgl_pkg::CFGL_CMD_STOP;
        endcase
    end

    cfgl_twi_byte u_byte (
        .clk       (clk),
        .rst_n     (rst_n),
        .cmd_valid (cmd_valid),
        .cmd       (cmd),
        .wdata     (wdata),
        .send_ack  (send_ack),
        .done      (byte_done),
        .rdata     (rdata),
        .ack_seen  (ack_seen),
        .sda_in    (sda_v_q),
        .scl_oe_n  (ee_scl_oe_n),
        .sda_oe_n  (ee_sda_oe_n)
    );

    // load sequencer; a missing acknowledge ends the load with a stop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q           <= S_START1;
            wait_q            <= 1'b0;
            eeprom_nack_error <= 1'b0;
            load_done         <= 1'b0;
        end else begin
            if (cmd_valid) begin
                wait_q <= 1'b1;
            end else if (byte_done) begin
                wait_q <= 1'b0;
                case (state_q)
                    S_START1: state_q <= S_DEVW;
                    S_DEVW, S_ADDR, S_DEVR: begin
                        if (!ack_seen) begin
                            eeprom_nack_error <= 1'b1;
                            state_q           <= S_STOP;
                        end else if (state_q == S_DEVW) begin
                            state_q <= S_ADDR;
                        end else if (state_q == S_ADDR) begin
                            state_q <= S_START2;
                        end else begin
                            state_q <= S_READ;
                        end
                    end
                    S_START2: state_q <= S_DEVR;
                    S_READ: begin
                        if (addr_q == cfgl_pkg::OFS_CSUM) begin
                            state_q <= S_STOP;
                        end
                    end
                    S_STOP: begin
                        state_q   <= S_DONE;
                        load_done <= 1'b1;
                    end
                    default: state_q <= S_DONE;
                endcase
            end
        end
    end

    // running sum of every byte before the checksum, kept to eight bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_q         <= cfgl_pkg::PART_START;
            sum_q          <= 8'h00;
            checksum_error <= 1'b0;
        end else if (byte_done && wait_q && state_q == S_READ) begin
            addr_q <= addr_q + 11'h001;
            if (addr_q == cfgl_pkg::OFS_CSUM) begin
                checksum_error <= (rdata != sum_q);
            end else begin
                sum_q <= sum_q + rdata;
            end
        end
    end

    // capture the table bytes this block owns as they stream past
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_enable_pad_ctrl_q <= cfgl_pkg::RST_PAD;
            frame_clock_pad_ctrl_q <= cfgl_pkg::RST_PAD;
            horizontal_extension_q <= cfgl_pkg::RST_HEXT;
            vertical_extension_q   <= cfgl_pkg::RST_VEXT;
            table_checksum_q       <= cfgl_pkg::RST_CSUM;
        end else if (byte_done && wait_q && state_q == S_READ) begin
            case (addr_q)
                cfgl_pkg::OFS_SYNC_EN:   sync_enable_pad_ctrl_q <= rdata;
                cfgl_pkg::OFS_FRAME_CLK: frame_clock_pad_ctrl_q <= rdata;
                cfgl_pkg::OFS_HEXT:      horizontal_extension_q <= rdata;
                cfgl_pkg::OFS_VEXT:
                    vertical_extension_q <= rdata[cfgl_pkg::EXT_D_LSB +:
                                                  cfgl_pkg::EXT_D_W];
                cfgl_pkg::OFS_CSUM:      table_checksum_q <= rdata;
                default:                 table_checksum_q <= table_checksum_q;
            endcase
        end
    end

    // pad enables and extensions take effect only after a clean load, so a corrupt table
    // leaves every pad floating rather than driving garbage into a panel
    assign cfg_ok = load_done && !checksum_error && !eeprom_nack_error;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_right <= 4'h0;
            ext_left  <= 4'h0;
            ext_down  <= 2'h0;
        end else begin
            ext_right <= cfg_ok ? horizontal_extension_q[cfgl_pkg::EXT_R_LSB +:
                         cfgl_pkg::EXT_W] : 4'h0;
            ext_left  <= cfg_ok ? horizontal_extension_q[cfgl_pkg::EXT_L_LSB +:
                         cfgl_pkg::EXT_W] : 4'h0;
            ext_down  <= cfg_ok ? vertical_extension_q : 2'h0;
        end
    end

    // pad enables, low-active toward the pad ring
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            display_enable_oe_n <= 1'b1;
            line_sync_oe_n      <= 1'b1;
            frame_sync_oe_n     <= 1'b1;
            panel_clock_oe_n    <= 1'b1;
        end else begin
            display_enable_oe_n <= !(cfg_ok &&
                sync_enable_pad_ctrl_q[cfgl_pkg::EN_HI_BIT]);
            line_sync_oe_n      <= !(cfg_ok &&
                sync_enable_pad_ctrl_q[cfgl_pkg::EN_LO_BIT]);
            frame_sync_oe_n     <= !(cfg_ok &&
                frame_clock_pad_ctrl_q[cfgl_pkg::EN_HI_BIT]);
            panel_clock_oe_n    <= !(cfg_ok &&
                frame_clock_pad_ctrl_q[cfgl_pkg::EN_LO_BIT]);
        end
    end

    // pad data and decoded drive currents
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            display_enable_out      <= 1'b0;
            line_sync_out           <= 1'b0;
            frame_sync_out          <= 1'b0;
            panel_clock_out         <= 1'b0;
            display_enable_drive_ma <= 4'h0;
            line_sync_drive_ma      <= 4'h0;
            frame_sync_drive_ma     <= 4'h0;
            panel_clock_drive_ma    <= 4'h0;
        end else begin
            display_enable_out      <= de_src;
            line_sync_out           <= line_sync_src;
            frame_sync_out          <= frame_sync_src;
            panel_clock_out         <= panel_clock_src;
            display_enable_drive_ma <= cfgl_pkg::cfgl_drive_ma(
                sync_enable_pad_ctrl_q[cfgl_pkg::DRV_HI_LSB +:
                                       cfgl_pkg::DRV_W]);
            line_sync_drive_ma      <= cfgl_pkg::cfgl_drive_ma(
                sync_enable_pad_ctrl_q[cfgl_pkg::DRV_LO_LSB +:
                                       cfgl_pkg::DRV_W]);
            frame_sync_drive_ma     <= cfgl_pkg::cfgl_drive_ma(
                frame_clock_pad_ctrl_q[cfgl_pkg::DRV_HI_LSB +:
                                       cfgl_pkg::DRV_W]);
            panel_clock_drive_ma    <= cfgl_pkg::cfgl_drive_ma(
                frame_clock_pad_ctrl_q[cfgl_pkg::DRV_LO_LSB +:
                                       cfgl_pkg::DRV_W]);
        end
    end

endmodule

// ===== logic/cfgl_pkg.sv
package cfgl_pkg;

    // clock and serial bus timing
    localparam int CLK_HZ  = 10_000_000;
    localparam int SCL_HZ  = 400_000;
    // quarter of one serial bit; a longest time, so it rounds down
    localparam int QTR_CYC = CLK_HZ / (4 * SCL_HZ);

    // serial memory device word, upper four bits; low bits carry addr[10:8]
    localparam logic [3:0] EE_DEV_HI = 4'ha;

    // table offsets inside the serial memory
    localparam logic [10:0] PART_START    = 11'h200;
    localparam logic [10:0] OFS_SYNC_EN   = 11'h266;
    localparam logic [10:0] OFS_FRAME_CLK = 11'h267;
    localparam logic [10:0] OFS_HEXT      = 11'h268;
    localparam logic [10:0] OFS_VEXT      = 11'h269;
    localparam logic [10:0] OFS_CSUM      = 11'h26a;

    // field positions inside a pad control byte
    localparam int EN_HI_BIT  = 7;
    localparam int EN_LO_BIT  = 3;
    localparam int DRV_HI_LSB = 4;
    localparam int DRV_LO_LSB = 0;
    localparam int DRV_W      = 3;

    // field positions inside the extension bytes
    localparam int EXT_R_LSB = 4;
    localparam int EXT_L_LSB = 0;
    localparam int EXT_W     = 4;
    localparam int EXT_D_LSB = 0;
    localparam int EXT_D_W   = 2;

    // reset values of the loaded table bytes
    localparam logic [7:0] RST_PAD  = 8'h00;
    localparam logic [7:0] RST_HEXT = 8'h00;
    localparam logic [1:0] RST_VEXT = 2'h0;
    localparam logic [7:0] RST_CSUM = 8'h00;

    // byte engine commands
    typedef enum logic [1:0] {
        CFGL_CMD_START,
        CFGL_CMD_STOP,
        CFGL_CMD_WRITE,
        CFGL_CMD_READ
    } cfgl_cmd_e;

    // drive code to pad current in mA
    function automatic logic [3:0] cfgl_drive_ma(input logic [2:0] code);
        case (code)
            3'h0:    cfgl_drive_ma = 4'h2;
            3'h1:    cfgl_drive_ma = 4'h6;
            3'h2:    cfgl_drive_ma = 4'h6;
            3'h3:    cfgl_drive_ma = 4'ha;
            3'h4:    cfgl_drive_ma = 4'h4;
            3'h5:    cfgl_drive_ma = 4'h8;
            3'h6:    cfgl_drive_ma = 4'h8;
            default: cfgl_drive_ma = 4'hc;
        endcase
    endfunction

endpackage

// ===== logic/cfgl_twi_byte.sv
`timescale 1ns/1ps
module cfgl_twi_byte (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // command side
    input  wire logic                cmd_valid,
    input  cfgl_pkg::cfgl_cmd_e      cmd,
    input  wire logic [7:0]          wdata,
    input  wire logic                send_ack,
    output logic                     done,
    output logic [7:0]               rdata,
    output logic                     ack_seen,
    // line side, sda already synchronised
    input  wire logic                sda_in,
    output logic                     scl_oe_n,
    output logic                     sda_oe_n
);

    logic                busy_q;
    logic [4:0]          div_q;
    logic                tick;
    logic [1:0]          phase_q;
    logic [3:0]          bit_q;
    logic                ack_q;
    cfgl_pkg::cfgl_cmd_e cmd_q;
    logic                rd_cmd;

    // read bytes leave data to the memory and drive only the ack slot
    assign rd_cmd = (cmd_q == cfgl_pkg::CFGL_CMD_READ);

    // quarter-bit enable; divider only runs while a command is in flight
    assign tick = busy_q && (div_q == 5'(cfgl_pkg::QTR_CYC - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 5'h00;
        end else if (!busy_q || tick) begin
            div_q <= 5'h00;
        end else begin
            div_q <= div_q + 5'h01;
        end
    end

    // four quarters per bit: set data, raise clock, sample, lower clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q   <= 1'b0;
            done     <= 1'b0;
            phase_q  <= 2'h0;
            bit_q    <= 4'h0;
            rdata    <= 8'h00;
            ack_q    <= 1'b0;
            ack_seen <= 1'b0;
            cmd_q    <= cfgl_pkg::CFGL_CMD_START;
            scl_oe_n <= 1'b1;
            sda_oe_n <= 1'b1;
        end else begin
            done <= 1'b0;
            if (!busy_q) begin
                if (cmd_valid) begin
                    busy_q  <= 1'b1;
                    cmd_q   <= cmd;
                    rdata   <= wdata;
                    ack_q   <= send_ack;
                    phase_q <= 2'h0;
                    bit_q   <= 4'h0;
                end
            end else if (tick) begin
                phase_q <= phase_q + 2'h1;
                case (cmd_q)
                    cfgl_pkg::CFGL_CMD_START: begin
                        // data falls while clock is high
                        case (phase_q)
                            2'h0:    sda_oe_n <= 1'b1;
                            2'h1:    scl_oe_n <= 1'b1;
                            2'h2:    sda_oe_n <= 1'b0;
                            default: begin
                                scl_oe_n <= 1'b0;
                                busy_q   <= 1'b0;
                                done     <= 1'b1;
                            end
                        endcase
                    end
                    cfgl_pkg::CFGL_CMD_STOP: begin
                        // data rises while clock is high
                        case (phase_q)
                            2'h0:    sda_oe_n <= 1'b0;
                            2'h1:    scl_oe_n <= 1'b1;
                            2'h2:    sda_oe_n <= 1'b1;
                            default: begin
                                busy_q <= 1'b0;
                                done   <= 1'b1;
                            end
                        endcase
                    end
                    default: begin
                        case (phase_q)
                            2'h0: begin
                                if (bit_q == 4'h8) begin
                                    // acknowledge slot
                                    sda_oe_n <= rd_cmd ? !ack_q : 1'b1;
                                end else begin
                                    sda_oe_n <= rd_cmd ? 1'b1 : rdata[7];
                                end
                            end
                            2'h1:    scl_oe_n <= 1'b1;
                            2'h2: begin
                                if (bit_q == 4'h8) begin
                                    ack_seen <= !sda_in;
                                end else begin
                                    rdata <= {rdata[6:0], sda_in};
                                end
                            end
                            default: begin
                                scl_oe_n <= 1'b0;
                                bit_q    <= bit_q + 4'h1;
                                if (bit_q == 4'h8) begin
                                    busy_q <= 1'b0;
                                    done   <= 1'b1;
                                end
                            end
                        endcase
                    end
                endcase
            end
        end
    end

endmodule

// ===== test/cfgl_ee_model.sv
`timescale 1ns/1ps
// behavioural serial memory; a released line reads high by the pull-up
module cfgl_ee_model (
    // bus wires
    input wire logic scl,
    input wire logic sda,
    output logic     sda_pull,
    // refuse the device word
    input wire logic nak
);
    logic [7:0]  mem [0:2047];
    logic [7:0]  sh;
    logic [7:0]  ob;
    logic [10:0] ad;
    logic [2:0]  ah;
    logic        ackm;
    int          bitc = 0;
    int          st = 3;
    initial sda_pull = 1'b0;
    // start and stop only count while the clock is high
    always @(negedge sda) if (scl) begin
        bitc = 0;
        st = 0;
    end
    always @(posedge sda) if (scl) st = 3;
    // data and the master's ack are sampled on the rising clock
    always @(posedge scl) begin
        if (bitc < 8) sh = {sh[6:0], sda};
        else ackm = sda;
        bitc++;
    end
    // sda moves only while the clock is low, so no false start or stop
    always @(negedge scl) begin
        sda_pull = 1'b0;
        if (bitc == 9) begin
            bitc = 0;
            if (st == 4 || (st == 2 && !ackm)) begin
                ob = mem[ad];
                ad++;
                st = 2;
            end else if (st == 2) st = 3; // master nack ends the read
        end
        if (st == 2 && bitc < 8) sda_pull = !ob[7-bitc]; // msb first
        else if (bitc == 8 && st == 0 && sh[7:4] == 4'ha && !nak) begin
            ah = sh[3:1];
            sda_pull = 1'b1;
            st = sh[0] ? 4 : 1;
        end else if (bitc == 8 && st == 1) begin
            ad = {ah, sh};
            sda_pull = 1'b1;
        end else if (bitc == 8 && st == 0) st = 3; // refused: line stays up
    end
endmodule

// ===== test/cfgl_loader_checker.sv
`timescale 1ns/1ps
module cfgl_loader_checker (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // pad sources and pads
    input wire logic       de_src,
    input wire logic       line_sync_src,
    input wire logic       frame_sync_src,
    input wire logic       panel_clock_src,
    input wire logic       display_enable_out,
    input wire logic       line_sync_out,
    input wire logic       frame_sync_out,
    input wire logic       panel_clock_out,
    input wire logic       display_enable_oe_n,
    input wire logic       line_sync_oe_n,
    input wire logic       frame_sync_oe_n,
    input wire logic       panel_clock_oe_n,
    input wire logic [3:0] display_enable_drive_ma,
    input wire logic [3:0] line_sync_drive_ma,
    input wire logic [3:0] frame_sync_drive_ma,
    input wire logic [3:0] panel_clock_drive_ma,
    // settings and status
    input wire logic [3:0] ext_right,
    input wire logic [3:0] ext_left,
    input wire logic [1:0] ext_down,
    input wire logic       load_done,
    input wire logic       checksum_error,
    input wire logic       eeprom_nack_error,
    // serial memory pin data, open drain
    input wire logic       ee_sda_out,
    input wire logic       ee_scl_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // grouped views of the four pads and the extensions
    wire [3:0] src4 = {de_src, line_sync_src, frame_sync_src, panel_clock_src};
    wire [3:0] out4 = {display_enable_out, line_sync_out, frame_sync_out,
                       panel_clock_out};
    wire [3:0] oe4 = {display_enable_oe_n, line_sync_oe_n, frame_sync_oe_n,
                      panel_clock_oe_n};
    wire [9:0] ext = {ext_right, ext_left, ext_down};
    // only the six documented currents may appear
    function automatic bit lg(input logic [3:0] m);
        lg = m inside {4'h2, 4'h4, 4'h6, 4'h8, 4'ha, 4'hc};
    endfunction
    property p_follow;
        $past(rst_n) |-> out4 == $past(src4);
    endproperty
    a_follow: assert property (p_follow) else $error("pad lag");
    property p_oe_wait;
        !load_done |-> oe4 == 4'hf;
    endproperty
    a_oe_wait: assert property (p_oe_wait) else $error("early pad");
    property p_ext_wait;
        !load_done |-> ext == 10'h000;
    endproperty
    a_ext_wait: assert property (p_ext_wait) else $error("early ext");
    property p_bad_tri;
        checksum_error || eeprom_nack_error |-> oe4 == 4'hf && ext == 10'h0;
    endproperty
    a_bad_tri: assert property (p_bad_tri) else $error("bad load");
    property p_ce_sticky;
        checksum_error |=> checksum_error;
    endproperty
    a_ce_sticky: assert property (p_ce_sticky) else $error("ce lost");
    property p_drive_ok;
        load_done |-> lg(display_enable_drive_ma) && lg(line_sync_drive_ma)
            && lg(frame_sync_drive_ma) && lg(panel_clock_drive_ma);
    endproperty
    a_drive_ok: assert property (p_drive_ok) else $error("bad drive");
    property p_ext_hold;
        load_done && $past(load_done, 2) |-> $stable(ext);
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("ext moved");
    property p_done_sticky;
        load_done |=> load_done;
    endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("off");
    property p_err_done;
        $rose(checksum_error) |-> ##[0:300] load_done;
    endproperty
    a_err_done: assert property (p_err_done) else $error("no end");
    // the memory pins may only ever pull low
    property p_od_low;
        ee_sda_out == 1'b0 && ee_scl_out == 1'b0;
    endproperty
    a_od_low: assert property (p_od_low) else $error("pin high");
endmodule
bind cfgl_loader cfgl_loader_checker u_chk (.*);

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        nak = 1'b0;
    logic [3:0]  src = 4'h0;
    logic [7:0]  rr = 8'h31;
    logic [7:0]  pr = 8'h31;
    logic        sda_pull;
    logic [31:0] exp_q [$];
    int          fails = 0;
    int          checks = 0;
    int          cyc = 0;
    wire         sda_oe_n, scl_oe_n, ld, ce, ne;
    wire [3:0]   oe, po, er, el;
    wire [15:0]  dm;
    wire [1:0]   ed;
    // open drain wires with pull-ups
    wire         sda = !(sda_pull || !sda_oe_n);
    wire         scl = scl_oe_n;
    cfgl_loader u_cfgl_loader (
        .clk(clk), .rst_n(rst_n), .ee_sda_in(sda), .ee_sda_out(),
        .ee_sda_oe_n(sda_oe_n), .ee_scl_out(), .ee_scl_oe_n(scl_oe_n),
        .de_src(src[3]), .line_sync_src(src[2]),
        .frame_sync_src(src[1]), .panel_clock_src(src[0]),
        .display_enable_out(po[3]), .display_enable_oe_n(oe[3]),
        .display_enable_drive_ma(dm[15:12]),
        .line_sync_out(po[2]), .line_sync_oe_n(oe[2]),
        .line_sync_drive_ma(dm[11:8]),
        .frame_sync_out(po[1]), .frame_sync_oe_n(oe[1]),
        .frame_sync_drive_ma(dm[7:4]),
        .panel_clock_out(po[0]), .panel_clock_oe_n(oe[0]),
        .panel_clock_drive_ma(dm[3:0]),
        .ext_right(er), .ext_left(el), .ext_down(ed), .load_done(ld),
        .checksum_error(ce), .eeprom_nack_error(ne)
    );
    cfgl_ee_model u_ee (.scl(scl), .sda(sda), .sda_pull(sda_pull), .nak(nak));
    function automatic logic [7:0] nx(input logic [7:0] s);
        nx = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [3:0] ma(input logic [2:0] c);
        case (c)
            3'h0: ma = 4'h2;
            3'h1, 3'h2: ma = 4'h6;
            3'h3: ma = 4'ha;
            3'h4: ma = 4'h4;
            3'h5, 3'h6: ma = 4'h8;
            default: ma = 4'hc;
        endcase
    endfunction
    // settings apply only after a clean load; drive is decoded regardless
    function automatic logic [31:0] expv(input logic [7:0] a, b, h, v,
                                         input logic ok, c, n);
        logic [3:0] en;
        en = ok ? {a[7], a[3], b[7], b[3]} : 4'h0;
        expv = {~en, ma(a[6:4]), ma(a[2:0]), ma(b[6:4]), ma(b[2:0]),
                ok ? h : 8'h00, ok ? v[1:0] : 2'h0, c, n};
    endfunction
    task wrap_up;
        if (fails == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task cmp(input logic [31:0] e, input logic [31:0] a);
        checks++;
        if (a !== e) begin
            fails++;
            $display("MISMATCH %0t load result %h expected %h", $time, a, e);
        end
    endtask
    // one load: fill the table, note the outcome, reset and wait
    task automatic run(input logic bad, input logic nk);
        logic [7:0] s;
        logic [7:0] a;
        logic [7:0] b;
        int         i;
        @(negedge clk);
        rst_n = 1'b0;
        nak = nk;
        s = 8'h00;
        for (i = 32'h200; i < 32'h26a; i++) begin
            rr = nx(rr);
            u_ee.mem[i] = rr;
            s = s + rr;
        end
        u_ee.mem[11'h26a] = s + {7'h00, bad};
        a = nk ? 8'h00 : u_ee.mem[11'h266];
        b = nk ? 8'h00 : u_ee.mem[11'h267];
        exp_q.push_back(expv(a, b, u_ee.mem[11'h268], u_ee.mem[11'h269],
                             !bad && !nk, bad, nk));
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        while (!ld) @(negedge clk);
        repeat (4) @(negedge clk);
    endtask
    initial forever #50 clk = ~clk;
    // pad sources toggle freely, as the timing logic would
    always @(negedge clk) begin
        pr = nx(pr);
        src <= pr[3:0];
    end
    // settings update one clock after done, so look two edges later
    initial forever begin
        @(posedge ld);
        repeat (2) @(negedge clk);
        cmp(exp_q.pop_front(), {oe, dm, er, el, ed, ce, ne});
    end
    // two full loads take about 49k cycles; leave some margin
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            wrap_up;
        end
    end
    initial begin
        run(1'b0, 1'b0);
        run(1'b1, 1'b0);
        run(1'b0, 1'b1);
        wrap_up;
    end
endmodule
